// file: arbm_buf2.sv
// Two-entry result buffer with valid and ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module arbm_buf2 #(
  parameter int WIDTH = 18
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  arbm_stream_if.snk in_s,
  arbm_stream_if.src out_s
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wp;
    logic                  rp;
    logic [1:0]            cnt;
  } arbm_buf_state_t;

  arbm_buf_state_t s_r;
  arbm_buf_state_t s_nxt;
  logic            push;
  logic            pop;

  if (WIDTH < 1) begin : g_chk
    $error("arbm_buf2: WIDTH must be at least 1");
  end

  // Full and empty come straight from the count, never guessed
  assign in_s.ready  = (s_r.cnt != 2'h2);
  assign out_s.valid = (s_r.cnt != 2'h0);
  assign out_s.data  = s_r.mem[s_r.rp];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_s.data;
      s_nxt.wp          = ~s_r.wp;
    end
    if (pop) begin
      s_nxt.rp = ~s_r.rp;
    end
    case ({push, pop})
      2'b10:   s_nxt.cnt = s_r.cnt + 2'h1;
      2'b01:   s_nxt.cnt = s_r.cnt - 2'h1;
      default: s_nxt.cnt = s_r.cnt;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : arbm_buf2

// file: arbm_host_model.sv
// Host side of the data bus: format, slice address, pop strobe.
// Assumes the bench merges its pins with the device enables.
`timescale 1ns/1ps
module arbm_host_model (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  alo_i,
  input  wire logic                  ahi_i,
  input  wire logic                  pop_i,
  input  wire logic                  valid_i,
  output logic                       next_o,
  output logic [arbm_pkg::RES_W-1:0] pin_o
);
  import arbm_pkg::*;
  logic             pend_r;
  logic [RES_W-4:0] junk_r;
  // Undriven lines toggle so a stale level never passes
  assign pin_o = {junk_r, ahi_i, alo_i, 1'b1};
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 1'b0;
      next_o <= 1'b0;
      junk_r <= '0;
    end else begin
      junk_r <= ~junk_r;
      // One strobe per word, only once a word waits
      next_o <= pend_r & valid_i & !next_o;
      pend_r <= (pend_r | pop_i) & !(pend_r & valid_i & !next_o);
    end
  end
endmodule : arbm_host_model

// file: arbm_pkg.sv
// Constants shared by the result bus multiplexer and its buffer.
// Assumes a 200 MHz core clock and an 18-bit result word.
package arbm_pkg;

  // ----------------------------------------------------------------
  // Widths and pin roles
  // ----------------------------------------------------------------
  localparam int          RES_W        = 18;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          PIN_FMT      = 0;
  localparam int          PIN_ALO      = 1;
  localparam int          PIN_AHI      = 2;
  localparam int          PIN_R0_WORD  = 2;
  localparam int          PIN_R0_BLO   = 10;
  localparam int          PIN_R0_BTOP  = 16;
  localparam int          BYTE_LSB     = 10;
  localparam int          MID_LSB      = 2;

  // ----------------------------------------------------------------
  // Interface modes, pin enable masks
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ARBM_MODE_PAR  = 2'h0,
    ARBM_MODE_WORD = 2'h1,
    ARBM_MODE_BYTE = 2'h2,
    ARBM_MODE_SER  = 2'h3
  } arbm_mode_t;

  localparam logic [RES_W-1:0] OE_ALL  = 18'h3FFFF;
  localparam logic [RES_W-1:0] OE_WORD = 18'h3FFFC;
  localparam logic [RES_W-1:0] OE_BYTE = 18'h3FC00;
  localparam logic [RES_W-1:0] OE_NONE = 18'h00000;

  // Range code is {bipolar, ten volt}
  localparam logic [1:0] RANGE_0_5   = 2'h0;
  localparam logic [1:0] RANGE_0_10  = 2'h1;
  localparam logic [1:0] RANGE_PM5   = 2'h2;
  localparam logic [1:0] RANGE_PM10  = 2'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h08;
  localparam int                CTRL_RANGE_LSB = 0;
  localparam int                CTRL_FMT_BIT   = 2;
  localparam logic [1:0]        CTRL_RANGE_RST = RANGE_0_5;
  localparam logic              CTRL_FMT_RST   = 1'b1;
  localparam int                ST_RANGE_LSB   = 0;
  localparam int                ST_BUSY_BIT    = 2;
  localparam int                ST_BUF_RDY_BIT = 3;
  localparam int                ST_RES_VLD_BIT = 4;
  localparam int                ST_PD_BIT      = 5;
  localparam int                ST_MODE_LSB    = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_TIME_NS  = 1000;
  localparam int CONV_CYCLES   =
    (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : arbm_pkg

// file: arbm_result_bus_mux.sv
// Result data bus multiplexer with conversion sequencer and registers.
// Assumes all pins are synchronous to ref_clk_i; the data pins are
// split into input, output and output enable for the pad ring.
//
// Summary of operation
// - Mode 00: all 18 result bits parallel
// - Word, addr low: result 2..17 on pins 2..17
// - Word, addr high: bits 0,1 on pins 2,3
// - Non-parallel modes: pins 0,1 become host inputs
// - Byte 00: bits 10..17 high, pins 3..9 float
// - Byte lo0 hi1: middle byte bits 2..9
// - Byte lo1 hi0: bits 0,1 on pins 10,11
// - Byte lo1 hi1: bits 0,1 on pins 16,17
// - Serial mode: all pins float, format input kept
// - Range pins choose range in hardware control
// - Serial software control: range from register
// - Start falling edge begins a conversion
// - Power-down finishes current, inhibits further conversions
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module arbm_result_bus_mux
  import arbm_pkg::*;
#(
  parameter int CONV_CYC = arbm_pkg::CONV_CYCLES
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        iface_sel_hi_i,
  input  wire logic                        iface_sel_lo_i,
  input  wire logic                        bipolar_range_pin_i,
  input  wire logic                        ten_volt_range_pin_i,
  input  wire logic                        range_ctrl_a_i,
  input  wire logic                        conv_start_n_i,
  input  wire logic                        power_down_in_i,
  input  wire logic [arbm_pkg::RES_W-1:0]  conv_sample_i,
  input  wire logic                        result_next_i,
  output logic                             result_valid_o,
  output logic [1:0]                       range_sel_o,
  output logic                             busy_o,
  input  wire logic [arbm_pkg::RES_W-1:0]  data_pin_i,
  output logic [arbm_pkg::RES_W-1:0]       data_pin_o,
  output logic [arbm_pkg::RES_W-1:0]       data_pin_oe_o,
  input  wire logic [arbm_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [arbm_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic [arbm_pkg::DATA_W-1:0]      reg_rdata_o
);
  import arbm_pkg::*;

  // ----------------------------------------------------------------
  // Checks and types
  // ----------------------------------------------------------------
  localparam int CNT_W  = $clog2(CONV_CYC + 1);
  localparam int BYTE_W = 8;

  if (CONV_CYC < 1) begin : g_chk
    $error("arbm_result_bus_mux: CONV_CYC must be at least 1");
  end

  if (RES_W > DATA_W) begin : g_chk_w
    $error("arbm_result_bus_mux: result wider than register data");
  end

  // Gray path: idle -> converting -> handing over -> idle
  // Done back to idle flips both bits; state is only read on the clock
  typedef enum logic [1:0] {
    ARBM_IDLE = 2'b00,
    ARBM_CONV = 2'b01,
    ARBM_DONE = 2'b11
  } arbm_conv_st_t;

  typedef struct packed {
    arbm_conv_st_t    st;
    logic [CNT_W-1:0] cnt;
    logic             start_n_prev;
    logic [RES_W-1:0] sample;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] pin_d;
    logic [RES_W-1:0] pin_oe;
    logic [1:0]       range;
    logic [1:0]       sw_range;
    logic             fmt_par;
    logic [DATA_W-1:0] rdata;
  } arbm_state_t;

  arbm_state_t s_r;
  arbm_state_t s_nxt;

  arbm_stream_if #(.W(RES_W)) fill_if ();
  arbm_stream_if #(.W(RES_W)) drain_if ();

  arbm_mode_t       mode;
  logic             addr_lo;
  logic             addr_hi;
  logic             fmt_ob;
  logic             start_fall;
  logic [RES_W-1:0] fmt_word;
  logic [2*RES_W-1:0] pins;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Offset binary input; clear selects two's complement
  function automatic logic [RES_W-1:0] fmt_code(
    input logic [RES_W-1:0] code,
    input logic             ob
  );
    logic [RES_W-1:0] w;
    w = code;
    if (!ob) begin
      w[RES_W-1] = ~code[RES_W-1];
    end
    return w;
  endfunction : fmt_code

  // Returns {enable, data} for the pins in the given mode and slice
  function automatic logic [2*RES_W-1:0] pin_map(
    input arbm_mode_t       m,
    input logic             a0,
    input logic             a1,
    input logic [RES_W-1:0] r
  );
    logic [RES_W-1:0] d;
    logic [RES_W-1:0] oe;
    d  = '0;
    oe = OE_NONE;
    case (m)
      ARBM_MODE_PAR: begin
        oe = OE_ALL;
        d  = r;
      end
      ARBM_MODE_WORD: begin
        oe = OE_WORD;
        if (!a0) begin
          d = {r[RES_W-1:PIN_R0_WORD], 2'h0};
        end else begin
          d[PIN_R0_WORD +: 2] = r[1:0];
        end
      end
      ARBM_MODE_BYTE: begin
        oe = OE_BYTE;
        case ({a0, a1})
          2'b00: d[BYTE_LSB +: BYTE_W] = r[BYTE_LSB +: BYTE_W];
          2'b01: d[BYTE_LSB +: BYTE_W] = r[MID_LSB +: BYTE_W];
          2'b10: d[PIN_R0_BLO +: 2] = r[1:0];
          default: d[PIN_R0_BTOP +: 2] = r[1:0];
        endcase
      end
      default: begin
        // Serial port lives elsewhere; this block leaves all pins
        oe = OE_NONE;
        d  = '0;
      end
    endcase
    return {oe, d};
  endfunction : pin_map

  // Busy from the start edge until the word is pushed
  function automatic logic seq_busy(input arbm_conv_st_t st);
    return (st != ARBM_IDLE);
  endfunction : seq_busy

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  assign mode    = arbm_mode_t'({iface_sel_hi_i, iface_sel_lo_i});
  // Address and format pins only mean something outside mode 00
  assign addr_lo = (mode != ARBM_MODE_PAR) && data_pin_i[PIN_ALO];
  assign addr_hi = (mode == ARBM_MODE_BYTE) && data_pin_i[PIN_AHI];
  assign fmt_ob  = (mode == ARBM_MODE_PAR) ? s_r.fmt_par
                                           : data_pin_i[PIN_FMT];
  assign fmt_word = fmt_code(s_r.result, fmt_ob);
  // One-cycle pin latency: slice address must not move mid-read
  assign pins     = pin_map(mode, addr_lo, addr_hi, fmt_word);
  assign start_fall = s_r.start_n_prev && !conv_start_n_i;

  // ----------------------------------------------------------------
  // Buffer between converter and bus
  // ----------------------------------------------------------------
  // Two entries let one host stall pass without losing a word
  assign fill_if.valid  = (s_r.st == ARBM_DONE);
  assign fill_if.data   = s_r.sample;
  assign drain_if.ready = result_next_i;

  arbm_buf2 #(
    .WIDTH     (RES_W)
  ) u_buf (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .in_s      (fill_if.snk),
    .out_s     (drain_if.src)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt              = s_r;
    s_nxt.start_n_prev = conv_start_n_i;
    s_nxt.pin_d        = pins[RES_W-1:0];
    s_nxt.pin_oe       = pins[2*RES_W-1:RES_W];

    // Conversion sequencer
    case (s_r.st)
      ARBM_IDLE: begin
        // Power-down only blocks new starts
        if (start_fall && !power_down_in_i) begin
          s_nxt.st  = ARBM_CONV;
          s_nxt.cnt = CNT_W'(CONV_CYC);
        end
      end
      ARBM_CONV: begin
        // Runs to completion even under power-down
        if (s_r.cnt == CNT_W'(1)) begin
          s_nxt.st     = ARBM_DONE;
          s_nxt.sample = conv_sample_i;
        end else begin
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
        end
      end
      ARBM_DONE: begin
        // Full buffer stalls here instead of dropping a word
        if (fill_if.ready) begin
          s_nxt.st = ARBM_IDLE;
        end
      end
      default: begin
        s_nxt.st = ARBM_IDLE;
      end
    endcase

    // Bus hold register takes the oldest buffered result
    if (drain_if.valid && drain_if.ready) begin
      s_nxt.result     = drain_if.data;
    end

    // Range selection
    if (mode == ARBM_MODE_SER && !range_ctrl_a_i) begin
      s_nxt.range = s_r.sw_range;
    end else begin
      s_nxt.range = {bipolar_range_pin_i, ten_volt_range_pin_i};
    end

    // Register writes
    if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      s_nxt.sw_range = reg_wdata_i[CTRL_RANGE_LSB +: 2];
      s_nxt.fmt_par  = reg_wdata_i[CTRL_FMT_BIT];
    end

    // Register reads, answered in the next cycle only
    s_nxt.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL: begin
          s_nxt.rdata[CTRL_RANGE_LSB +: 2] = s_r.sw_range;
          s_nxt.rdata[CTRL_FMT_BIT]        = s_r.fmt_par;
        end
        REG_STATUS: begin
          s_nxt.rdata[ST_RANGE_LSB +: 2] = s_r.range;
          s_nxt.rdata[ST_BUSY_BIT]       = seq_busy(s_r.st);
          s_nxt.rdata[ST_BUF_RDY_BIT]    = fill_if.ready;
          s_nxt.rdata[ST_RES_VLD_BIT]    = drain_if.valid;
          s_nxt.rdata[ST_PD_BIT]         = power_down_in_i;
          s_nxt.rdata[ST_MODE_LSB +: 2]  = mode;
        end
        REG_RESULT: begin
          s_nxt.rdata[RES_W-1:0] = s_r.result;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r              <= '0;
      s_r.st           <= ARBM_IDLE;
      s_r.start_n_prev <= 1'b1;
      s_r.sw_range     <= CTRL_RANGE_RST;
      s_r.fmt_par      <= CTRL_FMT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_pin_o     = s_r.pin_d;
  assign data_pin_oe_o  = s_r.pin_oe;
  assign range_sel_o    = s_r.range;
  assign busy_o         = seq_busy(s_r.st);
  assign result_valid_o = drain_if.valid;
  assign reg_rdata_o    = s_r.rdata;

endmodule : arbm_result_bus_mux

// file: arbm_result_bus_mux_properties.sv
// Port checker for the result bus multiplexer.
// Assumes it is bound into arbm_result_bus_mux.
`timescale 1ns/1ps
module arbm_mux_props (
  input wire logic                       ref_clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       iface_sel_hi_i,
  input wire logic                       iface_sel_lo_i,
  input wire logic                       bipolar_range_pin_i,
  input wire logic                       ten_volt_range_pin_i,
  input wire logic                       conv_start_n_i,
  input wire logic                       power_down_in_i,
  input wire logic                       busy_o,
  input wire logic [1:0]                 range_sel_o,
  input wire logic [arbm_pkg::RES_W-1:0] data_pin_i,
  input wire logic [arbm_pkg::RES_W-1:0] data_pin_o,
  input wire logic [arbm_pkg::RES_W-1:0] data_pin_oe_o
);
  import arbm_pkg::*;
  wire [1:0] md = {iface_sel_hi_i, iface_sel_lo_i};
  wire       lo = data_pin_i[1];
  wire       hi = data_pin_i[2];
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Pins, two cycles of steady mode since the address pins turn round
  // ----------------------------------------------------------------
  AST_PAR_OE: assert property (md == 2'h0 ##1 md == 2'h0 |=>
    data_pin_oe_o == 18'h3FFFF) else $error("parallel enables");
  AST_WORD_OE: assert property (md == 2'h1 ##1 md == 2'h1 |=>
    data_pin_oe_o == 18'h3FFFC) else $error("word enables");
  AST_BYTE_OE: assert property (md == 2'h2 ##1 md == 2'h2 |=>
    data_pin_oe_o == 18'h3FC00) else $error("byte enables");
  AST_SER_OE: assert property (md == 2'h3 ##1 md == 2'h3 |=>
    data_pin_oe_o == 18'h0) else $error("serial enables");
  AST_WORD_LOW: assert property ((md == 2'h1 && lo)[*2] |=>
    data_pin_o[17:4] == 14'h0) else $error("low word zeros");
  AST_BYTE_LOW: assert property ((md == 2'h2 && lo && !hi)[*2] |=>
    data_pin_o[17:12] == 6'h0) else $error("low byte zeros");
  AST_BYTE_TOP: assert property ((md == 2'h2 && lo && hi)[*2] |=>
    data_pin_o[15:10] == 6'h0) else $error("top byte zeros");
  // ----------------------------------------------------------------
  // Range and sequencer
  // ----------------------------------------------------------------
  AST_RANGE_HW: assert property (md != 2'h3 |=>
    range_sel_o == $past({bipolar_range_pin_i, ten_volt_range_pin_i}))
    else $error("range pins ignored");
  AST_START: assert property ($fell(conv_start_n_i) && !busy_o &&
    !power_down_in_i |=> busy_o) else $error("start not taken");
  AST_PD_HOLD: assert property (power_down_in_i && !busy_o |=>
    !busy_o) else $error("start under power down");
endmodule : arbm_mux_props

bind arbm_result_bus_mux arbm_mux_props chk_u (
  .ref_clk_i, .rst_n_i, .iface_sel_hi_i, .iface_sel_lo_i,
  .bipolar_range_pin_i, .ten_volt_range_pin_i, .conv_start_n_i,
  .power_down_in_i, .busy_o, .range_sel_o, .data_pin_i, .data_pin_o,
  .data_pin_oe_o
);

// file: arbm_stream_if.sv
// Valid/ready word carrier between the multiplexer and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface arbm_stream_if #(
  parameter int W = 18
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : arbm_stream_if

// file: test_adc_result_bus_mux.sv
// Self-checking bench for the result bus multiplexer.
// Assumes package, buffer, design and host model compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_adc_result_bus_mux;
  import arbm_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              iface_sel_hi_i = 1'b0;
  logic              iface_sel_lo_i = 1'b0;
  logic              bipolar_range_pin_i = 1'b0;
  logic              ten_volt_range_pin_i = 1'b0;
  logic              range_ctrl_a_i = 1'b1;
  logic              conv_start_n_i = 1'b1;
  logic              power_down_in_i = 1'b0;
  logic [RES_W-1:0]  conv_sample_i = '0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic              alo = 1'b0;
  logic              ahi = 1'b0;
  logic              pop = 1'b0;
  logic              result_next_i, result_valid_o, busy_o;
  logic [1:0]        range_sel_o;
  logic [RES_W-1:0]  data_pin_i, data_pin_o, data_pin_oe_o, host_pins;
  logic [DATA_W-1:0] reg_rdata_o;
  int                failures = 0;
  int                checks = 0;

  // Device enable wins a pin, the host fills the rest
  assign data_pin_i = (data_pin_o & data_pin_oe_o) |
                      (host_pins & ~data_pin_oe_o);

  arbm_result_bus_mux #(.CONV_CYC(3)) dut_u (
    .ref_clk_i, .rst_n_i, .iface_sel_hi_i, .iface_sel_lo_i,
    .bipolar_range_pin_i, .ten_volt_range_pin_i, .range_ctrl_a_i,
    .conv_start_n_i, .power_down_in_i, .conv_sample_i, .result_next_i,
    .result_valid_o, .range_sel_o, .busy_o, .data_pin_i, .data_pin_o,
    .data_pin_oe_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o
  );
  arbm_host_model host_u (
    .ref_clk_i, .rst_n_i, .alo_i(alo), .ahi_i(ahi), .pop_i(pop),
    .valid_i(result_valid_o), .next_o(result_next_i), .pin_o(host_pins)
  );

  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // Bus and stream helpers
  // ----------------------------------------------------------------
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : clk

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rreg

  task automatic conv(input logic [RES_W-1:0] c, input bit wt);
    @(posedge ref_clk_i);
    conv_sample_i  <= c;
    conv_start_n_i <= 1'b0;
    @(posedge ref_clk_i);
    conv_start_n_i <= 1'b1;
    repeat (50) begin
      #1;
      if (!wt || busy_o === 1'b0) break;
      @(posedge ref_clk_i);
    end
    if (wt) `CHK(busy_o, 1'b0)
  endtask : conv

  task automatic take(input logic [RES_W-1:0] e);
    logic [31:0] d;
    @(posedge ref_clk_i);
    pop <= 1'b1;
    @(posedge ref_clk_i);
    pop <= 1'b0;
    clk(4);
    rreg(REG_RESULT, d);
    `CHK(d, {14'h0, e})
  endtask : take

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rreg(REG_CTRL, d);
    `CHK(d, 32'h4)
    wreg(REG_CTRL, 32'h6);
    wreg(8'h10, 32'hFFFFFFFF);
    rreg(REG_CTRL, d);
    `CHK(d, 32'h6)
    rreg(8'h10, d);
    `CHK(d, 32'h0)
  endtask : t_regs

  task automatic t_pins();
    logic [RES_W-1:0] r, e, m;
    logic [1:0]       md, ad;
    r = 18'h2D5A6;
    conv(r, 1'b1);
    take(r);
    for (int i = 0; i < 8; i++) begin
      md = (i == 0) ? 2'h0 : (i < 3) ? 2'h1 : (i < 7) ? 2'h2 : 2'h3;
      ad = (i == 2) ? 2'h2 : (md == 2'h2) ? 2'(i - 3) : 2'h0;
      @(posedge ref_clk_i);
      {iface_sel_hi_i, iface_sel_lo_i} <= md;
      {alo, ahi} <= ad;
      clk(3);
      #1;
      m = (md == 2'h0) ? 18'h3FFFF : (md == 2'h1) ? 18'h3FFFC :
          (md == 2'h2) ? 18'h3FC00 : 18'h0;
      case ({md, ad})
        4'h0:    e = r;
        4'h4:    e = {r[17:2], 2'h0};
        4'h6:    e = {14'h0, r[1:0], 2'h0};
        4'h8:    e = {r[17:10], 10'h0};
        4'h9:    e = {r[9:2], 10'h0};
        4'hA:    e = {6'h0, r[1:0], 10'h0};
        4'hB:    e = {r[1:0], 16'h0};
        default: e = 18'h0;
      endcase
      `CHK(data_pin_oe_o, m)
      `CHK(data_pin_o & m, e)
    end
    // Two's complement flips the top bit in parallel mode
    wreg(REG_CTRL, 32'h2);
    @(posedge ref_clk_i);
    {iface_sel_hi_i, iface_sel_lo_i} <= 2'h0;
    clk(3);
    #1 `CHK(data_pin_o, r ^ 18'h20000)
    wreg(REG_CTRL, 32'h6);
  endtask : t_pins

  task automatic t_range();
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i);
      {iface_sel_hi_i, iface_sel_lo_i} <= (i > 3) ? 2'h3 : 2'h0;
      {bipolar_range_pin_i, ten_volt_range_pin_i} <= 2'(i);
      clk(3);
      #1 `CHK(range_sel_o, 2'(i))
    end
    @(posedge ref_clk_i);
    range_ctrl_a_i <= 1'b0;
    clk(3);
    #1 `CHK(range_sel_o, 2'h2)
    @(posedge ref_clk_i);
    range_ctrl_a_i <= 1'b1;
  endtask : t_range

  task automatic t_pd();
    @(posedge ref_clk_i);
    conv_sample_i  <= 18'h3FFFF;
    conv_start_n_i <= 1'b0;
    @(posedge ref_clk_i);
    conv_start_n_i  <= 1'b1;
    power_down_in_i <= 1'b1;
    clk(8);
    #1 `CHK({busy_o, result_valid_o}, 2'b01)
    take(18'h3FFFF);
    conv(18'h0, 1'b0);
    clk(8);
    #1 `CHK({busy_o, result_valid_o}, 2'b00)
    @(posedge ref_clk_i);
    power_down_in_i <= 1'b0;
  endtask : t_pd

  task automatic t_fill();
    // Third word waits in the sequencer until the first word is taken
    conv(18'h11111, 1'b1);
    conv(18'h22222, 1'b1);
    conv(18'h33333, 1'b0);
    clk(20);
    #1 `CHK(busy_o, 1'b1)
    take(18'h11111);
    `CHK(busy_o, 1'b0)
    take(18'h22222);
    take(18'h33333);
    `CHK(result_valid_o, 1'b0)
  endtask : t_fill

  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    failures++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_pins();
    t_range();
    t_pd();
    t_fill();
    finish_test();
  end
endmodule : test_adc_result_bus_mux
